// ---- rtl/pps_power_fsm.sv ----
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps

module pps_power_fsm #(
  parameter int CYC_PER_MS = pps_pkg::MS_CYC,
  parameter logic [pps_pkg::MSW-1:0] BTN_HOLD_MS = pps_pkg::BTN_HOLD_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // control pins
  input wire logic power_request_in,
  input wire logic push_button_in,
  input wire logic standby_in,
  input wire logic watchdog_fault_in,
  // supply and temperature monitors
  input wire logic thermal_shutdown_in,
  input wire logic thermal_release_in,
  input wire logic sys_above_uv_rise_in,
  input wire logic sys_below_uv_fall_in,
  input wire logic input_supply_in,
  // regulator sequencers
  output logic seq_up_start,
  input wire logic seq_up_done,
  output logic seq_down_start,
  input wire logic seq_down_done,
  // status
  output logic proc_reset_out_n,
  output logic deep_off_active
);

  localparam int MSW = pps_pkg::MSW;

  typedef struct packed {
    pps_pkg::pps_state_e st;
    logic [pps_pkg::NSYNC-1:0] s1;
    logic [pps_pkg::NSYNC-1:0] s2;
    logic dbn_req;
    logic dbn_prev;
    logic vin_prev;
    logic [15:0] div;
    logic tick;
    logic [9:0] dbc;
    logic [MSW-1:0] req_lo;
    logic [MSW-1:0] btn_lo;
    logic [MSW-1:0] st_ms;
    logic [10:0] ctrl;
    logic [pps_pkg::KEEP_W-1:0] keep;
    logic restart_arm;
    logic rst_n;
    logic deep;
    logic up_start;
    logic dn_start;
    logic [31:0] rdata;
  } pps_state_s;

  pps_state_s q_r;
  pps_state_s q_nxt;

  // ==========================================================
  // helpers
  function automatic logic [MSW-1:0] sat_inc(input logic [MSW-1:0] v);
    sat_inc = (v == pps_pkg::MS_MAX) ? v : v + 15'd1;
  endfunction : sat_inc

  function automatic logic [9:0] dbnc_len(input logic [1:0] sel);
    case (sel)
      2'h0: dbnc_len = pps_pkg::DBNC_MS0;
      2'h1: dbnc_len = pps_pkg::DBNC_MS1;
      2'h2: dbnc_len = pps_pkg::DBNC_MS2;
      default: dbnc_len = pps_pkg::DBNC_MS3;
    endcase
  endfunction : dbnc_len

  function automatic logic [10:0] rdly_len(input logic [2:0] sel);
    case (sel)
      3'h0: rdly_len = pps_pkg::RDLY_MS0;
      3'h1: rdly_len = pps_pkg::RDLY_MS1;
      3'h2: rdly_len = pps_pkg::RDLY_MS2;
      3'h3: rdly_len = pps_pkg::RDLY_MS3;
      3'h4: rdly_len = pps_pkg::RDLY_MS4;
      3'h5: rdly_len = pps_pkg::RDLY_MS5;
      3'h6: rdly_len = pps_pkg::RDLY_MS6;
      default: rdly_len = pps_pkg::RDLY_MS7;
    endcase
  endfunction : rdly_len

  // ==========================================================
  // decoded conditions
  logic edge_mode;
  logic any_keep;
  logic stby_req;
  logic req_fall;
  logic req_rise_short;
  logic long_evt;
  logic btn_hold;
  logic vin_rise;
  logic on_ok;
  logic off_evt;
  logic sleep_evt;
  logic turn_on;
  logic deep_go;
  logic deep_exit;
  logic long_off;
  logic [MSW-1:0] rdly_ms;

  always_comb begin
    edge_mode = q_r.ctrl[pps_pkg::CTRL_EDGE];
    any_keep = |q_r.keep;
    stby_req = q_r.s2[pps_pkg::I_STBY] ^ q_r.ctrl[pps_pkg::CTRL_STBYINV];
    req_fall = q_r.dbn_prev & ~q_r.dbn_req;
    // strictly under 4 s; 4 s itself is the long event
    req_rise_short = ~q_r.dbn_prev & q_r.dbn_req
      & (q_r.req_lo < pps_pkg::LONG_REQ_MS);
    // fires once per low period, on the tick the count hits 4 s
    long_evt = q_r.tick & ~q_r.dbn_req
      & (q_r.req_lo == pps_pkg::LONG_REQ_MS);
    btn_hold = q_r.ctrl[pps_pkg::CTRL_BTNRST] & (q_r.btn_lo > BTN_HOLD_MS);
    vin_rise = q_r.s2[pps_pkg::I_VIN] & ~q_r.vin_prev;
    rdly_ms = {4'h0, rdly_len(q_r.ctrl[pps_pkg::CTRL_RDLY +: 3])};

    on_ok = q_r.s2[pps_pkg::I_UVR] & q_r.s2[pps_pkg::I_TCOOL];
    long_off = edge_mode & long_evt & q_r.ctrl[pps_pkg::CTRL_LONGOFF]
      & ~any_keep;
    // read only in on states: watchdog masked until release
    off_evt = q_r.s2[pps_pkg::I_THOT]
      | q_r.s2[pps_pkg::I_UVF]
      | ~q_r.s2[pps_pkg::I_WDOG]
      | btn_hold
      | (~edge_mode & ~q_r.dbn_req & ~any_keep)
      | long_off
      | (edge_mode & long_evt & (q_r.st == pps_pkg::ST_SLEEP));
    sleep_evt = any_keep & ((~edge_mode & ~q_r.dbn_req)
      | (edge_mode & long_evt & q_r.ctrl[pps_pkg::CTRL_LONGOFF]));
    // auto-restart armed only by a long-request turn-off
    turn_on = on_ok & (edge_mode
      ? (req_fall | vin_rise
        | (q_r.restart_arm & q_r.ctrl[pps_pkg::CTRL_RESTART]
           & ~q_r.dbn_req & (q_r.req_lo > pps_pkg::RESTART_LOW_MS)
           & (q_r.st_ms > pps_pkg::RESTART_LOW_MS)))
      : q_r.dbn_req);
    // deep-off only from home, with input supply absent
    deep_go = ~q_r.s2[pps_pkg::I_VIN]
      & ((q_r.ctrl[pps_pkg::CTRL_DEEPREQ] & q_r.s2[pps_pkg::I_BTN])
         | btn_hold);
    // a wake press must begin inside deep-off
    deep_exit = q_r.s2[pps_pkg::I_VIN]
      | (~q_r.s2[pps_pkg::I_BTN] & (q_r.btn_lo > pps_pkg::DEEP_EXIT_MS)
         & (q_r.btn_lo <= q_r.st_ms));
  end

  // ==========================================================
  // next state
  always_comb begin
    q_nxt = q_r;
    q_nxt.up_start = 1'b0;
    q_nxt.dn_start = 1'b0;
    // two-stage input synchroniser
    q_nxt.s1 = {input_supply_in, sys_below_uv_fall_in, sys_above_uv_rise_in,
      thermal_release_in, thermal_shutdown_in, watchdog_fault_in,
      standby_in, push_button_in, power_request_in};
    q_nxt.s2 = q_r.s1;
    q_nxt.vin_prev = q_r.s2[pps_pkg::I_VIN];
    q_nxt.dbn_prev = q_r.dbn_req;

    // millisecond tick
    if (q_r.div == 16'(CYC_PER_MS - 1)) begin
      q_nxt.div = 16'h0000;
      q_nxt.tick = 1'b1;
    end else begin
      q_nxt.div = q_r.div + 16'h0001;
      q_nxt.tick = 1'b0;
    end

    // request debounce
    if (q_r.s2[pps_pkg::I_REQ] == q_r.dbn_req) begin
      q_nxt.dbc = 10'h000;
    end else if (q_r.tick) begin
      if (q_r.dbc + 10'h001 >= dbnc_len(q_r.ctrl[pps_pkg::CTRL_DBNC +: 2]))
      begin
        q_nxt.dbc = 10'h000;
        q_nxt.dbn_req = q_r.s2[pps_pkg::I_REQ];
      end else begin
        q_nxt.dbc = q_r.dbc + 10'h001;
      end
    end

    // low-time and state-time counters
    if (q_r.dbn_req) begin
      q_nxt.req_lo = '0;
    end else if (q_r.tick) begin
      q_nxt.req_lo = sat_inc(q_r.req_lo);
    end
    if (q_r.s2[pps_pkg::I_BTN]) begin
      q_nxt.btn_lo = '0;
    end else if (q_r.tick) begin
      q_nxt.btn_lo = sat_inc(q_r.btn_lo);
    end
    if (q_r.tick) begin
      q_nxt.st_ms = sat_inc(q_r.st_ms);
    end

    // register writes
    if (wr_en && addr == pps_pkg::REG_CTRL) begin
      q_nxt.ctrl = wr_data[10:0];
    end
    if (wr_en && addr == pps_pkg::REG_KEEP) begin
      q_nxt.keep = wr_data[pps_pkg::KEEP_W-1:0];
    end

    // power state machine
    case (q_r.st)
      pps_pkg::ST_OFF: begin
        q_nxt.rst_n = 1'b0;
        if (turn_on) begin
          q_nxt.st = pps_pkg::ST_PWRUP;
          q_nxt.up_start = 1'b1;
          q_nxt.restart_arm = 1'b0;
          q_nxt.st_ms = '0;
        end else if (deep_go) begin
          q_nxt.st = pps_pkg::ST_DEEP;
          q_nxt.st_ms = '0;
          // same-cycle control write wins over the clear
          if (!(wr_en && addr == pps_pkg::REG_CTRL)) begin
            q_nxt.ctrl[pps_pkg::CTRL_DEEPREQ] = 1'b0;
          end
        end
      end
      pps_pkg::ST_DEEP: begin
        q_nxt.rst_n = 1'b0;
        if (deep_exit) begin
          q_nxt.st = pps_pkg::ST_OFF;
          q_nxt.st_ms = '0;
        end
      end
      pps_pkg::ST_PWRUP: begin
        q_nxt.rst_n = 1'b0;
        // delay count starts once power-up is done
        q_nxt.st_ms = '0;
        if (seq_up_done) begin
          q_nxt.st = pps_pkg::ST_RSTDLY;
        end
      end
      pps_pkg::ST_RSTDLY: begin
        if (q_r.st_ms >= rdly_ms) begin
          q_nxt.rst_n = 1'b1;
          q_nxt.st = pps_pkg::ST_RUN;
        end
      end
      pps_pkg::ST_RUN, pps_pkg::ST_STBY, pps_pkg::ST_SLEEP: begin
        // reset drops as power-down starts, not at its end
        if (off_evt) begin
          q_nxt.st = pps_pkg::ST_PWRDN;
          q_nxt.dn_start = 1'b1;
          q_nxt.rst_n = 1'b0;
          q_nxt.restart_arm = long_off;
        end else if (q_r.st == pps_pkg::ST_SLEEP) begin
          // reset stays released across sleep and return
          if (edge_mode ? req_rise_short : q_r.dbn_req) begin
            q_nxt.st = pps_pkg::ST_RUN;
            q_nxt.up_start = 1'b1;
          end
        end else if (sleep_evt) begin
          // power-down starts, no wait for its done
          q_nxt.st = pps_pkg::ST_SLEEP;
          q_nxt.dn_start = 1'b1;
        end else if (q_r.st == pps_pkg::ST_RUN && stby_req) begin
          q_nxt.st = pps_pkg::ST_STBY;
        end else if (q_r.st == pps_pkg::ST_STBY && !stby_req) begin
          q_nxt.st = pps_pkg::ST_RUN;
        end
      end
      pps_pkg::ST_PWRDN: begin
        q_nxt.rst_n = 1'b0;
        if (seq_down_done) begin
          q_nxt.st = pps_pkg::ST_OFF;
          q_nxt.st_ms = '0;
        end
      end
      default: begin
        q_nxt.st = pps_pkg::ST_OFF;
        q_nxt.rst_n = 1'b0;
      end
    endcase
    // registered so the deep-off output comes from a flop
    q_nxt.deep = (q_nxt.st == pps_pkg::ST_DEEP);

    // register reads, data one cycle later
    q_nxt.rdata = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        pps_pkg::REG_CTRL: q_nxt.rdata = {21'h000000, q_r.ctrl};
        pps_pkg::REG_KEEP: q_nxt.rdata = {26'h0000000, q_r.keep};
        pps_pkg::REG_STAT: begin
          q_nxt.rdata[2:0] = q_r.st;
          q_nxt.rdata[pps_pkg::STAT_RSTO] = q_r.rst_n;
          q_nxt.rdata[pps_pkg::STAT_BTN] = q_r.s2[pps_pkg::I_BTN];
          q_nxt.rdata[pps_pkg::STAT_REQ] = q_r.dbn_req;
          q_nxt.rdata[pps_pkg::STAT_ARM] = q_r.restart_arm;
        end
        default: q_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r.st <= pps_pkg::ST_OFF;
      q_r.s1 <= '0;
      q_r.s2 <= '0;
      q_r.dbn_req <= 1'b0;
      q_r.dbn_prev <= 1'b0;
      q_r.vin_prev <= 1'b0;
      q_r.div <= 16'h0000;
      q_r.tick <= 1'b0;
      q_r.dbc <= 10'h000;
      q_r.req_lo <= '0;
      q_r.btn_lo <= '0;
      q_r.st_ms <= '0;
      q_r.ctrl <= pps_pkg::CTRL_RST;
      q_r.keep <= pps_pkg::KEEP_RST;
      q_r.restart_arm <= 1'b0;
      q_r.rst_n <= 1'b0;
      q_r.deep <= 1'b0;
      q_r.up_start <= 1'b0;
      q_r.dn_start <= 1'b0;
      q_r.rdata <= 32'h0000_0000;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign rd_data = q_r.rdata;
  assign proc_reset_out_n = q_r.rst_n;
  assign seq_up_start = q_r.up_start;
  assign seq_down_start = q_r.dn_start;
  assign deep_off_active = q_r.deep;

endmodule : pps_power_fsm

// ---- include/pps_pkg.sv ----
package pps_pkg;

  // ==========================================================
  // states
  typedef enum logic [2:0] {
    ST_OFF, ST_DEEP, ST_PWRUP, ST_RSTDLY, ST_RUN, ST_STBY, ST_SLEEP,
    ST_PWRDN
  } pps_state_e;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_KEEP = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;

  // control register fields
  localparam int CTRL_EDGE = 0;
  localparam int CTRL_BTNRST = 1;
  localparam int CTRL_LONGOFF = 2;
  localparam int CTRL_RESTART = 3;
  localparam int CTRL_DEEPREQ = 4;
  localparam int CTRL_STBYINV = 5;
  localparam int CTRL_DBNC = 6;
  localparam int CTRL_RDLY = 8;
  localparam logic [10:0] CTRL_RST = 11'h000;

  // keep register: buck bits [2:0], linear bits [5:3]
  localparam int KEEP_W = 6;
  localparam logic [KEEP_W-1:0] KEEP_RST = 6'h00;

  // status register fields, state in [2:0]
  localparam int STAT_RSTO = 4;
  localparam int STAT_BTN = 5;
  localparam int STAT_REQ = 6;
  localparam int STAT_ARM = 7;

  // synchronised input bit positions
  localparam int NSYNC = 9;
  localparam int I_REQ = 0;
  localparam int I_BTN = 1;
  localparam int I_STBY = 2;
  localparam int I_WDOG = 3;
  localparam int I_THOT = 4;
  localparam int I_TCOOL = 5;
  localparam int I_UVR = 6;
  localparam int I_UVF = 7;
  localparam int I_VIN = 8;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int MSW = 15;
  localparam logic [MSW-1:0] DEEP_EXIT_MS = 15'd1000;
  localparam int LONG_REQ_S = 4;
  localparam logic [MSW-1:0] LONG_REQ_MS = 15'(LONG_REQ_S * 1000);
  localparam logic [MSW-1:0] RESTART_LOW_MS = 15'd1000;
  localparam logic [MSW-1:0] BTN_HOLD_MS = 15'd4000;
  localparam logic [MSW-1:0] MS_MAX = 15'h7fff;

  // request debounce, ms per select code
  localparam logic [9:0] DBNC_MS0 = 10'd31;
  localparam logic [9:0] DBNC_MS1 = 10'd63;
  localparam logic [9:0] DBNC_MS2 = 10'd125;
  localparam logic [9:0] DBNC_MS3 = 10'd750;

  // reset release delay, ms per select code
  localparam logic [10:0] RDLY_MS0 = 11'd2;
  localparam logic [10:0] RDLY_MS1 = 11'd4;
  localparam logic [10:0] RDLY_MS2 = 11'd8;
  localparam logic [10:0] RDLY_MS3 = 11'd16;
  localparam logic [10:0] RDLY_MS4 = 11'd32;
  localparam logic [10:0] RDLY_MS5 = 11'd128;
  localparam logic [10:0] RDLY_MS6 = 11'd512;
  localparam logic [10:0] RDLY_MS7 = 11'd1024;

endpackage : pps_pkg

// ---- verif/pps_seq_model.sv ----
`timescale 1ns/1ps

module pps_seq_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // answer delay in cycles
  input wire logic [3:0] lag,
  // sequencer handshake
  input wire logic up_start,
  input wire logic down_start,
  output logic up_done,
  output logic down_done
);
  logic [4:0] up_cnt;
  logic [4:0] dn_cnt;

  // ======
  // done pulse a set lag after each start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_cnt <= 5'h00;
      dn_cnt <= 5'h00;
    end else begin
      up_cnt <= up_start ? {1'b0, lag} + 5'h01 : up_cnt - 5'(up_cnt != 0);
      dn_cnt <= down_start ? {1'b0, lag} + 5'h01 : dn_cnt - 5'(dn_cnt != 0);
    end
  end

  assign up_done = (up_cnt == 5'h01);
  assign down_done = (dn_cnt == 5'h01);
endmodule : pps_seq_model

// ---- verif/pps_power_fsm_assertions.sv ----
`timescale 1ns/1ps

module pps_power_fsm_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins and monitors
  input wire logic watchdog_fault_in,
  input wire logic thermal_shutdown_in,
  input wire logic thermal_release_in,
  input wire logic sys_above_uv_rise_in,
  input wire logic sys_below_uv_fall_in,
  input wire logic input_supply_in,
  // sequencer and status
  input wire logic seq_up_start,
  input wire logic seq_up_done,
  input wire logic seq_down_start,
  input wire logic proc_reset_out_n,
  input wire logic deep_off_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ======
  // power-up finished since last start
  logic up_ok_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_ok_r <= 1'b0;
    end else if (seq_up_start || seq_down_start) begin
      up_ok_r <= 1'b0;
    end else if (seq_up_done) begin
      up_ok_r <= 1'b1;
    end
  end

  // ======
  // sequences
  sequence s_no_power;
    (!thermal_release_in || !sys_above_uv_rise_in) [*5];
  endsequence
  sequence s_cold_start;
    seq_up_start && !proc_reset_out_n;
  endsequence

  // ======
  // assertions
  a_off_reset_low: assert property (
    deep_off_active |-> !proc_reset_out_n) else $error("reset out high");
  a_no_power_on: assert property (
    s_no_power |-> not s_cold_start) else $error("turn-on without power");
  a_wdog_turns_off: assert property (
    proc_reset_out_n && !watchdog_fault_in |-> ##[0:40] !proc_reset_out_n)
    else $error("watchdog ignored");
  a_therm_turns_off: assert property (
    $rose(thermal_shutdown_in) && proc_reset_out_n |-> ##[1:40]
    !proc_reset_out_n) else $error("thermal ignored");
  a_uv_turns_off: assert property (
    proc_reset_out_n && sys_below_uv_fall_in |-> ##[0:40] !proc_reset_out_n)
    else $error("undervoltage ignored");
  a_fall_starts_down: assert property (
    $fell(proc_reset_out_n) |-> seq_down_start) else $error("no power-down");
  a_rise_after_up: assert property (
    $rose(proc_reset_out_n) |-> up_ok_r) else $error("early reset release");
  a_supply_no_deep: assert property (
    input_supply_in [*6] |-> !deep_off_active) else $error("deep with supply");
endmodule : pps_power_fsm_chk

bind pps_power_fsm pps_power_fsm_chk u_chk (
  .clk(clk), .rst(rst), .watchdog_fault_in(watchdog_fault_in),
  .thermal_shutdown_in(thermal_shutdown_in),
  .thermal_release_in(thermal_release_in),
  .sys_above_uv_rise_in(sys_above_uv_rise_in),
  .sys_below_uv_fall_in(sys_below_uv_fall_in),
  .input_supply_in(input_supply_in), .seq_up_start(seq_up_start),
  .seq_up_done(seq_up_done), .seq_down_start(seq_down_start),
  .proc_reset_out_n(proc_reset_out_n), .deep_off_active(deep_off_active)
);

// ---- verif/pps_power_fsm_bench.sv ----
`timescale 1ns/1ps

module pps_power_fsm_bench;
  localparam logic [2:0] OFF = pps_pkg::ST_OFF, DEEP = pps_pkg::ST_DEEP;
  localparam logic [2:0] RUN = pps_pkg::ST_RUN, STBY = pps_pkg::ST_STBY;
  localparam logic [2:0] SLEEP = pps_pkg::ST_SLEEP;
  localparam logic [7:0] CTRL = pps_pkg::REG_CTRL, STAT = pps_pkg::REG_STAT;
  localparam logic [31:0] INV = 32'h1 << pps_pkg::CTRL_STBYINV;
  localparam logic [31:0] DQ = 32'h1 << pps_pkg::CTRL_DEEPREQ;
  localparam logic [31:0] BR = 32'h1 << pps_pkg::CTRL_BTNRST;
  // ======
  // signals
  logic clk, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data, d;
  logic preq = 1'b0, btn = 1'b1, stby = 1'b0, wdog = 1'b1;
  logic thot = 1'b0, tcool = 1'b1, uvr = 1'b1, uvf = 1'b0, vin = 1'b1;
  logic up_s, up_d, dn_s, dn_d, rst_out_n, deep;
  logic [3:0] lag = 4'h1;
  int n_mismatch = 0, n_checks = 0, cyc_cnt = 0;

  pps_power_fsm #(.CYC_PER_MS(4), .BTN_HOLD_MS(15'd20)) uut (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .power_request_in(preq), .push_button_in(btn), .standby_in(stby),
    .watchdog_fault_in(wdog), .thermal_shutdown_in(thot),
    .thermal_release_in(tcool), .sys_above_uv_rise_in(uvr),
    .sys_below_uv_fall_in(uvf), .input_supply_in(vin),
    .seq_up_start(up_s), .seq_up_done(up_d), .seq_down_start(dn_s),
    .seq_down_done(dn_d), .proc_reset_out_n(rst_out_n),
    .deep_off_active(deep)
  );
  pps_seq_model sqm (
    .clk(clk), .rst(rst), .lag(lag), .up_start(up_s),
    .down_start(dn_s), .up_done(up_d), .down_done(dn_d)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 80000) begin
      n_mismatch++;
      $display("[ERR] %0t run timed out", $time);
      finish_test();
    end
  end

  // ======
  // tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask : rd

  task automatic wait_st(input logic [2:0] s, input int n);
    int i;
    i = 0;
    rd(STAT, d);
    while (d[2:0] !== s && i < n) begin
      rd(STAT, d);
      i++;
    end
    chk(32'(d[2:0]), 32'(s));
  endtask : wait_st

  // ======
  // sequence of tests
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wr(8'h0c, 32'hffffffff);
    rd(CTRL, d);
    chk(d, 32'h0);
    rd(8'h0c, d);
    chk(d, 32'h0);
    rd(pps_pkg::REG_KEEP, d);
    chk(d, 32'h0);
    wait_st(OFF, 0);
    chk(32'(rst_out_n), 32'h0);
    @(posedge clk) {tcool, preq} <= 2'b01;
    repeat (300) @(posedge clk);
    wait_st(OFF, 0);
    @(posedge clk) {tcool, preq} <= 2'b10;
    repeat (300) @(posedge clk);
    @(posedge clk) preq <= 1'b1;
    repeat (80) @(posedge clk);
    wait_st(OFF, 0);
    wait_st(RUN, 200);
    chk(32'(rst_out_n), 32'h1);
    @(posedge clk) stby <= 1'b1;
    wait_st(STBY, 20);
    wr(CTRL, INV);
    wait_st(RUN, 20);
    @(posedge clk) stby <= 1'b0;
    wait_st(STBY, 20);
    wr(CTRL, 32'h0);
    wait_st(RUN, 20);
    wr(pps_pkg::REG_KEEP, 32'h1);
    @(posedge clk) preq <= 1'b0;
    wait_st(SLEEP, 200);
    chk(32'(rst_out_n), 32'h1);
    @(posedge clk) preq <= 1'b1;
    wait_st(RUN, 200);
    wr(pps_pkg::REG_KEEP, 32'h0);
    @(posedge clk) preq <= 1'b0;
    wait_st(OFF, 200);
    @(posedge clk) preq <= 1'b1;
    wait_st(RUN, 300);
    wr(pps_pkg::REG_KEEP, 32'h8);
    wr(CTRL, DQ);
    @(posedge clk) {lag, preq} <= {4'h8, 1'b0};
    wait_st(SLEEP, 200);
    @(posedge clk) wdog <= 1'b0;
    wait_st(OFF, 30);
    @(posedge clk) {wdog, lag} <= {1'b1, 4'h1};
    wr(pps_pkg::REG_KEEP, 32'h0);
    repeat (50) @(posedge clk);
    wait_st(OFF, 0);
    @(posedge clk) vin <= 1'b0;
    wait_st(DEEP, 30);
    chk(32'({deep, rst_out_n}), 32'h2);
    @(posedge clk) vin <= 1'b1;
    wait_st(OFF, 30);
    @(posedge clk) vin <= 1'b0;
    wr(CTRL, DQ);
    wait_st(DEEP, 30);
    @(posedge clk) btn <= 1'b0;
    repeat (3900) @(posedge clk);
    wait_st(DEEP, 0);
    wait_st(OFF, 200);
    @(posedge clk) btn <= 1'b1;
    wr(CTRL, BR);
    @(posedge clk) btn <= 1'b0;
    wait_st(DEEP, 60);
    @(posedge clk) {btn, vin} <= 2'b11;
    wait_st(OFF, 30);
    wr(CTRL, 32'hf);
    @(posedge clk) preq <= 1'b1;
    repeat (300) @(posedge clk);
    wait_st(OFF, 0);
    @(posedge clk) preq <= 1'b0;
    wait_st(RUN, 300);
    repeat (15000) @(posedge clk);
    wait_st(RUN, 0);
    wait_st(OFF, 1000);
    wait_st(RUN, 3000);
    @(posedge clk) btn <= 1'b0;
    wait_st(OFF, 60);
    repeat (200) @(posedge clk);
    wait_st(OFF, 0);
    @(posedge clk) btn <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) vin <= 1'b0;
      repeat (20) @(posedge clk);
      @(posedge clk) vin <= 1'b1;
      wait_st(RUN, 300);
      @(posedge clk) {thot, uvf} <= (k == 0) ? 2'b10 : 2'b01;
      wait_st(OFF, 60);
      @(posedge clk) {thot, uvf} <= 2'b00;
    end
    finish_test();
  end
endmodule : pps_power_fsm_bench
